// >>> core/frs_key_unlock.sv
// Two-value key unlock tracker
`timescale 1ns/1ps
module frs_key_unlock (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        reg_write_i,
  input  wire logic        key_write_i,
  input  wire logic [7:0]  key_data_i,
  input  wire logic        consume_i,
  output logic             unlocked_o
);
  import frs_pkg::*;
  frs_key_t key_state;
  // Any other register write relocks, so keys must immediately precede start
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      key_state <= FRS_KEY_IDLE;
    end else if (consume_i) begin
      key_state <= FRS_KEY_IDLE;
    end else if (reg_write_i) begin
      if (key_write_i && key_data_i == FRS_KEY_FIRST) begin
        key_state <= FRS_KEY_HALF;
      end else if (key_write_i && key_data_i == FRS_KEY_SECOND && key_state == FRS_KEY_HALF) begin
        key_state <= FRS_KEY_OPEN;
      end else begin
        key_state <= FRS_KEY_IDLE;
      end
    end
  end
  assign unlocked_o = (key_state == FRS_KEY_OPEN);

  chk_key_relock: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    reg_write_i && !key_write_i |=> !unlocked_o)
    else $error("key not relocked");
endmodule : frs_key_unlock

// >>> core/frs_pkg.sv
// Package for the flash row erase/program sequencer
package frs_pkg;
  localparam int unsigned FRS_AW = 4;
  localparam logic [3:0] FRS_OFF_CONTROL  = 4'h0;
  localparam logic [3:0] FRS_OFF_KEY      = 4'h4;
  localparam logic [3:0] FRS_OFF_ADDR_LO  = 4'h8;
  localparam logic [3:0] FRS_OFF_ADDR_HI  = 4'hC;
  localparam int unsigned FRS_BIT_START  = 15;
  localparam int unsigned FRS_BIT_WRITE_ENABLE_BIT   = 14;
  localparam logic [3:0] FRS_OP_ERASE    = 4'h3;
  localparam logic [3:0] FRS_OP_ROW      = 4'h2;
  localparam logic [15:0] FRS_CTRL_RESET = 16'h0000;
  localparam logic [15:0] FRS_CTRL_MASK  = 16'hC00F;
  localparam logic [7:0] FRS_KEY_FIRST   = 8'h55;
  localparam logic [7:0] FRS_KEY_SECOND  = 8'hAA;
  localparam int unsigned FRS_ROWS_PER_BLOCK = 8;
  localparam int unsigned FRS_INSTR_PER_ROW  = 128;
  localparam logic [7:0] FRS_ADDR_HI_MASK = 8'hFF;
  typedef enum logic [1:0] {
    FRS_KEY_IDLE = 2'b00,
    FRS_KEY_HALF = 2'b01,
    FRS_KEY_OPEN = 2'b10
  } frs_key_t;
  typedef enum logic [1:0] {
    FRS_ST_IDLE  = 2'b00,
    FRS_ST_ISSUE = 2'b01,
    FRS_ST_BUSY  = 2'b10
  } frs_state_t;
endpackage : frs_pkg

// >>> core/frs_sequencer.sv
// Flash row erase / program sequencer with Avalon-MM register slave
// What this block does
// - Program one row; erase whole 8-row block
// - Operation code 0011 selects block erase
// - Operation code 0010 selects row programming
// - No operation starts without key unlock
// - Start bit 15 launches selected cycle
// - CPU stalled until flash operation finishes
// - Hardware clears start bit on completion
// - Value 4003h sets erase with write enable
`timescale 1ns/1ps
module frs_sequencer (
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic [frs_pkg::FRS_AW-1:0] avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  output logic                         flash_erase_o,
  output logic                         flash_program_o,
  output logic      [23:0]             flash_addr_o,
  input  wire logic                    flash_done_i,
  output logic                         cpu_stall_o
);
  import frs_pkg::*;

  logic [15:0]   flash_op_control;
  logic [15:0]   target_address_low;
  logic [7:0]    target_address_high;
  frs_state_t    state;
  logic          rd_done;
  logic          wr_hit_ctrl;
  logic          wr_hit_key;
  logic          start_req;
  logic          unlocked;
  logic          launch;
  logic [15:0]   next_ctrl;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // Writes complete in one cycle; reads take one wait cycle for registered data
  wire bus_wr = avs_write;
  assign avs_waitrequest = avs_read && !rd_done;
  assign wr_hit_ctrl = bus_wr && avs_address == FRS_OFF_CONTROL;
  assign wr_hit_key  = bus_wr && avs_address == FRS_OFF_KEY && avs_byteenable[0];
  assign next_ctrl   = merge16(flash_op_control, avs_writedata, avs_byteenable) & FRS_CTRL_MASK;
  assign start_req   = wr_hit_ctrl && next_ctrl[FRS_BIT_START] && state == FRS_ST_IDLE;
  // Write enable must be set in this same write, in the same byte lane as the start bit
  assign launch = start_req && unlocked && next_ctrl[FRS_BIT_WRITE_ENABLE_BIT]
                  && (next_ctrl[3:0] == FRS_OP_ERASE || next_ctrl[3:0] == FRS_OP_ROW);

  frs_key_unlock i_frs_key_unlock (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .reg_write_i (bus_wr),
    .key_write_i (wr_hit_key),
    .key_data_i  (avs_writedata[7:0]),
    .consume_i   (start_req),
    .unlocked_o  (unlocked)
  );

  // Control register; fields frozen during a cycle so the operation cannot shift
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_op_control <= FRS_CTRL_RESET;
    end else if (state == FRS_ST_BUSY && flash_done_i) begin
      flash_op_control[FRS_BIT_START] <= 1'b0;
    end else if (wr_hit_ctrl && state == FRS_ST_IDLE) begin
      flash_op_control <= {launch, next_ctrl[14:0]};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      target_address_low  <= 16'h0000;
      target_address_high <= 8'h00;
    end else if (bus_wr && state == FRS_ST_IDLE) begin
      if (avs_address == FRS_OFF_ADDR_LO) begin
        target_address_low <= merge16(target_address_low, avs_writedata, avs_byteenable);
      end else if (avs_address == FRS_OFF_ADDR_HI && avs_byteenable[0]) begin
        target_address_high <= avs_writedata[7:0] & FRS_ADDR_HI_MASK;
      end
    end
  end

  // Sequencer: issue one-cycle command, then wait for the array
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= FRS_ST_IDLE;
    end else begin
      case (state)
        FRS_ST_IDLE: begin
          if (launch) begin
            state <= FRS_ST_ISSUE;
          end
        end
        FRS_ST_ISSUE: begin
          state <= FRS_ST_BUSY;
        end
        FRS_ST_BUSY: begin
          if (flash_done_i) begin
            state <= FRS_ST_IDLE;
          end
        end
        default: begin
          state <= FRS_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_erase_o   <= 1'b0;
      flash_program_o <= 1'b0;
      flash_addr_o    <= 24'h00_0000;
    end else begin
      flash_erase_o   <= state == FRS_ST_ISSUE && flash_op_control[3:0] == FRS_OP_ERASE;
      flash_program_o <= state == FRS_ST_ISSUE && flash_op_control[3:0] == FRS_OP_ROW;
      if (state == FRS_ST_ISSUE) begin
        flash_addr_o <= {target_address_high, target_address_low};
      end
    end
  end

  assign cpu_stall_o = state != FRS_ST_IDLE;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_done      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_done <= avs_read && !rd_done;
      if (avs_read && !rd_done) begin
        if (avs_address == FRS_OFF_CONTROL) begin
          avs_readdata <= {16'h0000, flash_op_control};
        end else if (avs_address == FRS_OFF_ADDR_LO) begin
          avs_readdata <= {16'h0000, target_address_low};
        end else if (avs_address == FRS_OFF_ADDR_HI) begin
          avs_readdata <= {24'h00_0000, target_address_high};
        end else begin
          avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end

  // Sequencer checks; covers mark the main flows
  chk_start_stalls: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    launch |=> cpu_stall_o && flash_op_control[FRS_BIT_START])
    else $error("start did not stall");

  chk_done_clears: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == FRS_ST_BUSY && flash_done_i |=> !flash_op_control[FRS_BIT_START] && !cpu_stall_o)
    else $error("start bit not cleared");

  chk_locked_refused: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    start_req && !unlocked |=> !cpu_stall_o)
    else $error("locked start ran");

  chk_write_enable_bit_needed: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    start_req && !next_ctrl[FRS_BIT_WRITE_ENABLE_BIT] |=> state == FRS_ST_IDLE)
    else $error("start without write_enable_bit");

  chk_erase_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    launch && next_ctrl[3:0] == FRS_OP_ERASE |=> ##1 flash_erase_o && !flash_program_o)
    else $error("erase not issued");

  chk_row_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    launch && next_ctrl[3:0] == FRS_OP_ROW |=> ##1 flash_program_o && !flash_erase_o)
    else $error("program not issued");

  chk_start_reads: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cpu_stall_o |-> flash_op_control[FRS_BIT_START])
    else $error("start reads zero while busy");

  chk_one_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    flash_erase_o |=> !flash_erase_o)
    else $error("erase pulse too long");

  chk_prog_one_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    flash_program_o |=> !flash_program_o)
    else $error("program pulse too long");

  chk_bad_op_refused: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    start_req && next_ctrl[3:0] != FRS_OP_ERASE && next_ctrl[3:0] != FRS_OP_ROW |=> !cpu_stall_o)
    else $error("unknown operation ran");

  chk_start_low_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !cpu_stall_o |-> !flash_op_control[FRS_BIT_START])
    else $error("start bit set while idle");

  // A shifting field mid-cycle would retarget the array
  chk_busy_frozen: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cpu_stall_o && !flash_done_i |=> $stable(flash_op_control))
    else $error("control changed while busy");

  chk_stall_holds: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == FRS_ST_BUSY && !flash_done_i |=> cpu_stall_o)
    else $error("stall dropped early");

  chk_pulse_in_stall: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    flash_erase_o || flash_program_o |-> cpu_stall_o)
    else $error("array command outside stall");

  chk_write_nowait: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    avs_write |-> !avs_waitrequest)
    else $error("write was stalled");

  cov_erase: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) flash_erase_o);
  cov_program: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) flash_program_o);
  cov_refused: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) start_req && !launch);
  cov_busy_write: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) cpu_stall_o && wr_hit_ctrl);
  cov_bad_op: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) start_req && unlocked && !launch);
endmodule : frs_sequencer

// >>> dv/frs_flash_model.sv
// Behavioural flash array that answers erase and row program pulses
`timescale 1ns/1ps
module frs_flash_model #(
  parameter int unsigned DLY = 12
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic erase_i,
  input  wire logic program_i,
  output logic      done_o
);
  int unsigned cnt;
  // Block erase and row program differ only in array effect, not in timing here
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= 0;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt == 1);
      // Row data taken as already loaded into the latches
      if (erase_i || program_i) begin
        cnt <= DLY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : frs_flash_model

// >>> dv/tb.sv
// Self-checking testbench for the flash sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb;
  import frs_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        flash_erase_o;
  logic        flash_program_o;
  logic        flash_done_i;
  logic        cpu_stall_o;
  logic [23:0] flash_addr_o;
  int          failures = 0;
  int          compares = 0;
  int          cyc = 0;
  frs_sequencer i_frs_sequencer (.core_clk_i, .rst_n_i, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .flash_erase_o, .flash_program_o, .flash_addr_o,
    .flash_done_i, .cpu_stall_o);
  frs_flash_model #(.DLY(12)) i_frs_flash_model (.core_clk_i, .rst_n_i, .erase_i(flash_erase_o),
    .program_i(flash_program_o), .done_o(flash_done_i));
  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task automatic end_sim();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // Hang guard; a full run needs well under a thousand cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      end_sim();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] be = 4'hF);
    @(posedge core_clk_i);
    avs_address    <= a;
    avs_writedata  <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    do @(posedge core_clk_i); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge core_clk_i); while (avs_waitrequest !== 1'b0);
    `CHK(avs_readdata, e)
    avs_read <= 1'b0;
  endtask : rd
  // k: 0 no keys, 1 proper keys, 2 keys split by another write
  task automatic launch(input logic [15:0] c, input logic [15:0] al, input int k, input logic ee, input logic ep);
    logic [3:0] ne;
    logic [3:0] np;
    wr(4'h0, c & 16'h7FFF);
    wr(4'h8, al);
    wr(4'hC, 16'h0056);
    if (k > 0) wr(4'h4, 16'h0055);
    if (k > 1) wr(4'h8, al);
    if (k > 0) wr(4'h4, 16'h00AA);
    wr(4'h0, c);
    ne = 4'h0;
    np = 4'h0;
    // Idle cycles after start stand in for the no-operations
    repeat (6) begin
      @(posedge core_clk_i);
      ne = ne + {3'b000, flash_erase_o};
      np = np + {3'b000, flash_program_o};
      if (flash_erase_o || flash_program_o) `CHK({cpu_stall_o, flash_addr_o}, {1'b1, 8'h56, al})
    end
    `CHK(ne, {3'b000, ee})
    `CHK(np, {3'b000, ep})
    if (ee || ep) begin
      rd(4'h0, {16'h0000, c});
      // Busy write must leave the launched fields alone
      wr(4'h0, 16'h0000);
      repeat (30) if (cpu_stall_o !== 1'b0) @(posedge core_clk_i);
      `CHK(cpu_stall_o, 1'b0)
    end
    rd(4'h0, {16'h0000, c & 16'h7FFF});
  endtask : launch
  task automatic t_reset();
    rd(4'h0, 32'h0000_0000);
    rd(4'h4, 32'h0000_0000);
    rd(4'h2, 32'h0000_0000);
    wr(4'h8, 16'h1234);
    wr(4'h8, 16'hABCD, 4'h1);
    rd(4'h8, 32'h0000_12CD);
  endtask : t_reset
  task automatic t_erase();
    launch(16'hC003, 16'h1200, 1, 1'b1, 1'b0);
  endtask : t_erase
  task automatic t_program();
    launch(16'hC002, 16'h1200, 1, 1'b0, 1'b1);
    launch(16'hC002, 16'h1300, 1, 1'b0, 1'b1);
  endtask : t_program
  task automatic t_refused();
    launch(16'hC003, 16'h1234, 0, 1'b0, 1'b0);
    launch(16'hC002, 16'h1234, 2, 1'b0, 1'b0);
    launch(16'h8003, 16'h1234, 1, 1'b0, 1'b0);
    launch(16'hC001, 16'h1234, 1, 1'b0, 1'b0);
  endtask : t_refused
  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_erase();
    t_program();
    t_refused();
    t_erase();
    end_sim();
  end
endmodule : tb
